// [core/nfs_host.sv]
// Host controller issuing set-feature and get-feature sequences to the flash target.
// Function
// - ECC on: EFh, 90h, 08h 00h 00h 00h, then wait busy time.
// - ECC off: EFh, 90h, four 00h bytes, then wait busy time.
// - Host waits address-to-data delay before the first parameter byte.
// - After polling with 70h host issues 00h before reading parameters.
// - After busy host reads four parameter bytes in order.
`default_nettype none
module nfs_host #(
  parameter int BUSY_TIMEOUT_CYC = 50000 // Longest wait for ready, in clocks spent reading status.
) (
  input wire logic clk, // 50 MHz clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic req_valid, // Request present.
  input wire nfs_pkg::nfs_req_s req, // Request contents.
  output logic req_ready, // Idle and able to take a request.
  output logic [31:0] resp_params, // Parameters read, first byte in bits 7:0.
  output logic resp_valid, // Pulse: request finished.
  output logic resp_timeout, // Pulse with resp_valid: ready never came.
  input wire logic [7:0] io_in, // Data pins from device.
  output logic [7:0] io_out, // Data pins to device.
  output logic io_oe, // High while host drives data pins.
  output nfs_pkg::nfs_pins_s pins, // Control strobes.
  input wire logic busy_n // Ready/busy line, low while busy.
);
  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_ADDR, S_GAP, S_WDATA, S_BUSYSTART, S_POLLCMD,
    S_POLLRD, S_RDMODE, S_RDATA, S_DONE
  } nfs_st_e;
  nfs_st_e st_r, st_nxt;
  nfs_pkg::nfs_req_s rq_r, rq_nxt;
  logic [1:0] idx_r, idx_nxt;
  logic [nfs_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [31:0] rp_r, rp_nxt;
  logic tmo_r, tmo_nxt;
  logic cstart;
  nfs_pkg::nfs_cyc_e ckind;
  logic [7:0] cwdata, crdata;
  logic cdone;
  logic started_r, started_nxt;

  // Params written: reserved bits cleared, bytes two to four forced zero.
  function automatic logic [7:0] clean_p1(input logic [7:0] fa, input logic [7:0] p);
    // only defined addresses are decoded; reserved ones pass unchanged.
    case (fa)
      nfs_pkg::FA_TIMING: clean_p1 = {5'h00, p[2:0] & nfs_pkg::TIMING_MODE_MASK};
      nfs_pkg::FA_DRIVE, nfs_pkg::FA_PULLDOWN: clean_p1 = {6'h00, p[1:0]};
      nfs_pkg::FA_ARRAY_MODE: clean_p1 = {4'h0, p[3], 2'h0, p[0]} | {6'h00, p[1] & p[0], 1'b0};
      default: clean_p1 = p;
    endcase
  endfunction

  function automatic logic [7:0] wr_byte(input logic [7:0] fa, input logic [31:0] ps,
                                         input logic [1:0] i);
    wr_byte = (i == 2'h0) ? clean_p1(fa, ps[7:0]) : nfs_pkg::PARAM_ZERO;
  endfunction

  // Sequencer next-state logic.
  always_comb begin
    st_nxt = st_r;
    rq_nxt = rq_r;
    idx_nxt = idx_r;
    cnt_nxt = cnt_r;
    rp_nxt = rp_r;
    tmo_nxt = tmo_r;
    started_nxt = started_r;
    cstart = 1'b0;
    ckind = nfs_pkg::CYC_CMD;
    cwdata = nfs_pkg::PARAM_ZERO;
    case (st_r)
      S_IDLE: begin
        // only start while device is idle
        if (req_valid && busy_n) begin
          rq_nxt = req;
          tmo_nxt = 1'b0;
          rp_nxt = 32'h0000_0000;
          started_nxt = 1'b0;
          st_nxt = S_CMD;
        end
      end
      S_CMD: begin
        ckind = nfs_pkg::CYC_CMD;
        cwdata = rq_r.is_get ? nfs_pkg::CMD_GET_FEAT : nfs_pkg::CMD_SET_FEAT;
        cstart = !started_r;
        started_nxt = 1'b1;
        if (cdone) begin
          started_nxt = 1'b0;
          st_nxt = S_ADDR;
        end
      end
      S_ADDR: begin
        ckind = nfs_pkg::CYC_ADDR;
        cwdata = rq_r.addr;
        cstart = !started_r;
        started_nxt = 1'b1;
        if (cdone) begin
          started_nxt = 1'b0;
          idx_nxt = 2'h0;
          cnt_nxt = rq_r.is_get ? nfs_pkg::CNT_W'(nfs_pkg::BUSY_START_CYC)
                                : nfs_pkg::CNT_W'(nfs_pkg::ADDR_TO_DATA_CYC);
          st_nxt = rq_r.is_get ? S_BUSYSTART : S_GAP;
        end
      end
      S_GAP: begin
        cnt_nxt = cnt_r - nfs_pkg::CNT_ONE;
        if (cnt_r <= nfs_pkg::CNT_ONE) st_nxt = S_WDATA;
      end
      S_WDATA: begin
        ckind = nfs_pkg::CYC_WDATA;
        cwdata = wr_byte(rq_r.addr, rq_r.params, idx_r);
        cstart = !started_r;
        started_nxt = 1'b1;
        if (cdone) begin
          started_nxt = 1'b0;
          idx_nxt = idx_r + 2'h1;
          if (idx_r == 2'(nfs_pkg::NUM_PARAMS - 1)) begin
            cnt_nxt = nfs_pkg::CNT_W'(nfs_pkg::BUSY_START_CYC);
            st_nxt = S_BUSYSTART;
          end
        end
      end
      S_BUSYSTART: begin
        // Let the busy line fall before sampling it.
        cnt_nxt = cnt_r - nfs_pkg::CNT_ONE;
        if (cnt_r <= nfs_pkg::CNT_ONE) begin
          cnt_nxt = BUSY_TIMEOUT_CYC[nfs_pkg::CNT_W-1:0];
          st_nxt = S_POLLCMD;
        end
      end
      S_POLLCMD: begin
        ckind = nfs_pkg::CYC_CMD;
        cwdata = nfs_pkg::CMD_STATUS;
        cstart = !started_r;
        started_nxt = 1'b1;
        if (cdone) begin
          started_nxt = 1'b0;
          st_nxt = S_POLLRD;
        end
      end
      S_POLLRD: begin
        ckind = nfs_pkg::CYC_RDATA;
        cstart = !started_r;
        started_nxt = 1'b1;
        // Saturate so that a limit that is not a multiple of a read cannot wrap past the check.
        if (cnt_r != '0) cnt_nxt = cnt_r - nfs_pkg::CNT_ONE;
        if (cdone) begin
          started_nxt = 1'b0;
          if (crdata[nfs_pkg::STATUS_READY_BIT] && busy_n) begin
            st_nxt = rq_r.is_get ? S_RDMODE : S_DONE;
          end else if (cnt_r <= nfs_pkg::CNT_ONE) begin
            tmo_nxt = 1'b1;
            st_nxt = S_DONE;
          end
        end
      end
      S_RDMODE: begin
        ckind = nfs_pkg::CYC_CMD;
        cwdata = nfs_pkg::CMD_READ_MODE;
        cstart = !started_r;
        started_nxt = 1'b1;
        if (cdone) begin
          started_nxt = 1'b0;
          idx_nxt = 2'h0;
          st_nxt = S_RDATA;
        end
      end
      S_RDATA: begin
        ckind = nfs_pkg::CYC_RDATA;
        cstart = !started_r;
        started_nxt = 1'b1;
        if (cdone) begin
          started_nxt = 1'b0;
          rp_nxt[8*idx_r +: 8] = crdata;
          idx_nxt = idx_r + 2'h1;
          if (idx_r == 2'(nfs_pkg::NUM_PARAMS - 1)) st_nxt = S_DONE;
        end
      end
      S_DONE: st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
  end

  // State registers; nothing here issues a reset command before features.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= S_IDLE;
      rq_r <= '0;
      idx_r <= 2'h0;
      cnt_r <= '0;
      rp_r <= 32'h0000_0000;
      tmo_r <= 1'b0;
      started_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      rq_r <= rq_nxt;
      idx_r <= idx_nxt;
      cnt_r <= cnt_nxt;
      rp_r <= rp_nxt;
      tmo_r <= tmo_nxt;
      started_r <= started_nxt;
    end
  end

  nfs_cycle u_cycle (
    .clk(clk),
    .arst_n(arst_n),
    .start(cstart),
    .kind(ckind),
    .wdata(cwdata),
    .io_in(io_in),
    .io_out(io_out),
    .io_oe(io_oe),
    .pins(pins),
    .rdata(crdata),
    .done(cdone)
  );

  // Handshake outputs are decoded from state; req_ready also needs busy_n high.
  assign req_ready = (st_r == S_IDLE) && busy_n;
  assign resp_valid = (st_r == S_DONE);
  assign resp_timeout = (st_r == S_DONE) && tmo_r;
  assign resp_params = rp_r;

  ////////////////////////////////////////////////////////////////////////////
  // reserved addresses still forwarded unchanged; decode only shapes the first byte.

  // bytes two to four are zero on the bus
  a_upper_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (st_r == S_WDATA && idx_r != 2'h0 && io_oe) |-> io_out == nfs_pkg::PARAM_ZERO)
    else $error("nonzero reserved parameter byte");
  // the busy wait starts right after the fourth data byte
  a_four_bytes: assert property (@(posedge clk) disable iff (!arst_n)
    (st_r == S_WDATA && cdone && idx_r == 2'h3) |=> st_r == S_BUSYSTART)
    else $error("set-feature did not move to busy after fourth byte");
  a_addr_gap: assert property (@(posedge clk) disable iff (!arst_n)
    (st_r == S_ADDR && cdone && !rq_r.is_get) |=> (st_r == S_GAP) [*3])
    else $error("address-to-data delay too short");
  a_idle_start: assert property (@(posedge clk) disable iff (!arst_n)
    (st_r == S_IDLE && !busy_n) |=> st_r == S_IDLE)
    else $error("request started while device busy");
  a_rdmode_first: assert property (@(posedge clk) disable iff (!arst_n)
    (st_r != S_RDATA) ##1 (st_r == S_RDATA) |-> $past(st_r) == S_RDMODE)
    else $error("parameter read without read-mode command");
  a_set_code: assert property (@(posedge clk) disable iff (!arst_n)
    (st_r == S_CMD && pins.cle && !rq_r.is_get) |-> io_out == nfs_pkg::CMD_SET_FEAT)
    else $error("wrong set-feature command code");
  a_get_code: assert property (@(posedge clk) disable iff (!arst_n)
    (st_r == S_CMD && pins.cle && rq_r.is_get) |-> io_out == nfs_pkg::CMD_GET_FEAT)
    else $error("wrong get-feature command code");
  a_ready_seen: assert property (@(posedge clk) disable iff (!arst_n)
    (st_r == S_POLLRD && cdone && !busy_n) |=> st_r != S_DONE || tmo_r)
    else $error("finished while busy line low");
endmodule
`default_nettype wire

// [core/nfs_pkg.sv]
// Package of constants and carrier types for the feature set/get host controller.
`default_nettype none
package nfs_pkg;
  // Command codes driven on the data pins during command cycles.
  localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
  localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_MODE = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  // Feature addresses.
  localparam logic [7:0] FA_TIMING = 8'h01;
  localparam logic [7:0] FA_DRIVE = 8'h80;
  localparam logic [7:0] FA_PULLDOWN = 8'h81;
  localparam logic [7:0] FA_ARRAY_MODE = 8'h90;
  // Array operation mode first parameter encodings.
  localparam logic [7:0] AM_NORMAL = 8'h00;
  localparam logic [7:0] AM_OTP_OP = 8'h01;
  localparam logic [7:0] AM_OTP_PROT = 8'h03;
  localparam logic [7:0] AM_ECC_ON = 8'h08;
  localparam logic [7:0] PARAM_ZERO = 8'h00;
  localparam logic [2:0] TIMING_MODE_MASK = 3'h7;
  localparam logic [7:0] TIMING_MODE_MAX = 8'h05;
  // Ready bit position in the status byte.
  localparam int STATUS_READY_BIT = 6;
  localparam int NUM_PARAMS = 4;
  // Bus timing at a 50 MHz clock.
  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDR_TO_DATA_DELAY_NS = 70;
  localparam int ADDR_TO_DATA_CYC =
    (ADDR_TO_DATA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_LOW_NS = 40;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FEATURE_BUSY_TIME_NS = 1000;
  localparam int FEATURE_BUSY_CYC =
    (FEATURE_BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_START_NS = 100;
  localparam int BUSY_START_CYC = (BUSY_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  // Bus pin group driven toward the device.
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
  } nfs_pins_s;
  // One user request.
  typedef struct packed {
    logic is_get;
    logic [7:0] addr;
    logic [31:0] params;
  } nfs_req_s;
  // Kind of bus cycle issued by the cycle engine.
  typedef enum logic [1:0] {CYC_CMD, CYC_ADDR, CYC_WDATA, CYC_RDATA} nfs_cyc_e;
endpackage
`default_nettype wire

// [core/nfs_cycle.sv]
// One asynchronous bus cycle engine: command, address, data write or data read.
`default_nettype none
module nfs_cycle (
  input wire logic clk, // 50 MHz clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic start, // Pulse: begin one cycle.
  input wire nfs_pkg::nfs_cyc_e kind, // Cycle kind.
  input wire logic [7:0] wdata, // Byte to drive.
  input wire logic [7:0] io_in, // Data pins from the device.
  output logic [7:0] io_out, // Data pins driven.
  output logic io_oe, // High while driving data pins.
  output nfs_pkg::nfs_pins_s pins, // Strobes and latches.
  output logic [7:0] rdata, // Byte captured on a read cycle.
  output logic done // Pulse: cycle finished.
);
  typedef enum logic [1:0] {C_IDLE, C_LOW, C_HIGH} nfs_cst_e;
  nfs_cst_e st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  nfs_pkg::nfs_cyc_e kind_r, kind_nxt;
  logic [7:0] wd_r, wd_nxt, rd_r, rd_nxt;
  localparam logic [3:0] LOW_CYC = 4'(nfs_pkg::STROBE_LOW_CYC);

  // Next-state logic; the strobe rises at the end of the low phase.
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    kind_nxt = kind_r;
    wd_nxt = wd_r;
    rd_nxt = rd_r;
    case (st_r)
      C_IDLE: begin
        if (start) begin
          st_nxt = C_LOW;
          cnt_nxt = LOW_CYC;
          kind_nxt = kind;
          wd_nxt = wdata;
        end
      end
      C_LOW: begin
        if (cnt_r == 4'h1) begin
          st_nxt = C_HIGH;
          if (kind_r == nfs_pkg::CYC_RDATA) rd_nxt = io_in;
        end
        cnt_nxt = cnt_r - 4'h1;
      end
      C_HIGH: st_nxt = C_IDLE;
      default: st_nxt = C_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= C_IDLE;
      cnt_r <= 4'h0;
      kind_r <= nfs_pkg::CYC_CMD;
      wd_r <= 8'h00;
      rd_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      kind_r <= kind_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
    end
  end

  // Pins are decoded from state; chip enable held low while a cycle runs.
  always_comb begin
    pins.ce_n = (st_r == C_IDLE);
    pins.cle = (st_r != C_IDLE) && (kind_r == nfs_pkg::CYC_CMD);
    pins.ale = (st_r != C_IDLE) && (kind_r == nfs_pkg::CYC_ADDR);
    pins.we_n = !((st_r == C_LOW) && (kind_r != nfs_pkg::CYC_RDATA));
    pins.read_strobe_n = !((st_r == C_LOW) && (kind_r == nfs_pkg::CYC_RDATA));
  end
  assign io_oe = (st_r != C_IDLE) && (kind_r != nfs_pkg::CYC_RDATA);
  assign io_out = wd_r;
  assign rdata = rd_r;
  assign done = (st_r == C_HIGH);
endmodule
`default_nettype wire

// [bench/nfs_dev_model.sv]
// Behavioural flash target that answers feature set/get and status reads.
`default_nettype none
module nfs_dev_model (
  input wire nfs_pkg::nfs_pins_s pins, // Strobes and latches from the host.
  input wire logic [7:0] io_out, // Data pins driven by the host.
  input var int busy_ns, // Length of each busy interval in ns.
  output logic [7:0] io_in, // Data pins driven by the target.
  output logic busy_n // Ready/busy line, low while busy.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] feat [256];
  logic [7:0] cmd_r, fa_r, last_r, drv;
  logic stat_mode, ecc_on;
  int idx, nbytes;
  realtime t_addr, gap_ns;
  // only the first array-mode byte steers internal ECC.
  assign ecc_on = feat[nfs_pkg::FA_ARRAY_MODE][3];
  ////////////////////////////////////////////////////////////////////////////////
  // every setting powers up as zero.
  initial begin
    foreach (feat[i]) feat[i] = 32'h0;
    busy_n = 1'b1;
    cmd_r = 8'hFF;
    fa_r = 8'h00;
    last_r = 8'h00;
    stat_mode = 1'b0;
    idx = 0;
    nbytes = 0;
  end
  // busy is released by a delayed update so a long interval can overrun the host.
  task automatic go_busy();
    busy_n = 1'b0;
    busy_n <= #(busy_ns) 1'b1;
  endtask
  // one byte latched per rising write strobe, decoded by cycle kind.
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.cle) begin
      // status is taken while busy, feature commands only when idle.
      if (io_out == nfs_pkg::CMD_STATUS) stat_mode = 1'b1;
      else if (io_out == nfs_pkg::CMD_READ_MODE) stat_mode = 1'b0;
      else if (busy_n || !(io_out inside {nfs_pkg::CMD_SET_FEAT, nfs_pkg::CMD_GET_FEAT})) begin
        cmd_r = io_out;
        stat_mode = 1'b0;
      end
    end else if (!pins.ce_n && pins.ale) begin
      fa_r = io_out;
      idx = 0;
      nbytes = 0;
      t_addr = $realtime;
      if (cmd_r == nfs_pkg::CMD_GET_FEAT) go_busy();
    end else if (!pins.ce_n && cmd_r == nfs_pkg::CMD_SET_FEAT) begin
      nbytes++;
      // any address stores four bytes; the gap before the first is recorded.
      if (idx == 0) gap_ns = $realtime - t_addr;
      if (idx < 4) begin
        feat[fa_r][idx*8 +: 8] = io_out;
        idx++;
        if (idx == 4) go_busy();
      end
    end
  end
  // first parameter first, one per read strobe; status bit 6 mirrors the busy line.
  always_comb begin
    drv = stat_mode ? {1'b1, busy_n, 6'h00} : 8'(feat[fa_r] >> (8 * idx));
    io_in = (!pins.ce_n && !pins.read_strobe_n) ? drv : ~last_r;
  end
  // Released pins show the inverse of the last byte so stale data cannot pass.
  always @(posedge pins.read_strobe_n) begin
    if (!pins.ce_n) begin
      last_r = drv;
      if (!stat_mode) idx++;
    end
  end
endmodule
`default_nettype wire

// [bench/nfs_host_tb.sv]
// Self-checking testbench for the feature set/get host controller.
`default_nettype none
module nfs_host_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, arst_n, req_valid, req_ready, resp_valid, resp_timeout, io_oe, busy_n, tmo;
  logic [31:0] resp_params, got;
  logic [7:0] io_in, io_out, v, a;
  logic [7:0] shadow [256];
  logic [7:0] am_codes [4];
  nfs_pkg::nfs_req_s req;
  nfs_pkg::nfs_pins_s pins;
  int busy_ns, bad_count, cmp_count, cyc;
  initial clk = 1'b0;
  always #10 clk = ~clk;
  nfs_host #(.BUSY_TIMEOUT_CYC(200)) dut (.clk(clk), .arst_n(arst_n), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .resp_params(resp_params), .resp_valid(resp_valid),
    .resp_timeout(resp_timeout), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .pins(pins),
    .busy_n(busy_n));
  nfs_dev_model model (.pins(pins), .io_out(io_out), .busy_ns(busy_ns), .io_in(io_in),
    .busy_n(busy_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Settled first parameter after the host clears reserved bits of defined addresses.
  function automatic logic [7:0] clean(input logic [7:0] fa, input logic [7:0] p);
    case (fa)
      nfs_pkg::FA_TIMING: return p & 8'h07;
      nfs_pkg::FA_DRIVE, nfs_pkg::FA_PULLDOWN: return p & 8'h03;
      nfs_pkg::FA_ARRAY_MODE: return p[0] ? (p & 8'h0B) : (p & 8'h08);
      default: return p;
    endcase
  endfunction
  // One request, held until taken, then a bounded wait for its answer.
  task automatic xfer(input logic g, input logic [7:0] fa, input logic [31:0] p,
                      output logic [31:0] r, output logic t);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{is_get: g, addr: fa, params: p};
    n = 0;
    // The request stands until the edge at which ready is seen high.
    do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 500);
    req_valid <= 1'b0;
    chk(req_ready, 1'b1);
    n = 0;
    do begin @(posedge clk); #1; n++; end while (resp_valid !== 1'b1 && n < 2000);
    chk(resp_valid, 1'b1);
    r = resp_params;
    t = resp_timeout;
  endtask
  // Write the first parameter with junk in the other three, then read it back.
  task automatic set_get(input logic [7:0] fa, input logic [7:0] p);
    xfer(1'b0, fa, {24'($urandom), p}, got, tmo);
    shadow[fa] = clean(fa, p);
    chk(tmo, 1'b0);
    chk(32'(model.nbytes), 32'd4);
    chk(model.gap_ns >= nfs_pkg::ADDR_TO_DATA_DELAY_NS, 1'b1);
    chk(model.feat[fa], {24'h0, shadow[fa]});
    xfer(1'b1, fa, 32'h0, got, tmo);
    chk(got, {24'h0, shadow[fa]});
  endtask
  // The host must drive the data pins at each write strobe and release them for reads.
  always @(posedge pins.we_n) begin
    #1;
    if (pins.ce_n === 1'b0) chk(io_oe, 1'b1);
  end
  always @(negedge pins.read_strobe_n) begin
    #1;
    if (pins.ce_n === 1'b0) chk(io_oe, 1'b0);
  end
  // Watchdog over the whole run.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hAAD4));
    arst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    busy_ns = 600;
    bad_count = 0;
    cmp_count = 0;
    cyc = 0;
    foreach (shadow[i]) shadow[i] = 8'h00;
    am_codes = '{nfs_pkg::AM_ECC_ON, nfs_pkg::AM_OTP_OP, nfs_pkg::AM_OTP_PROT, nfs_pkg::AM_NORMAL};
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    xfer(1'b1, nfs_pkg::FA_TIMING, 32'h0, got, tmo);
    chk(got, 32'h0);
    xfer(1'b1, nfs_pkg::FA_ARRAY_MODE, 32'h0, got, tmo);
    chk(got, 32'h0);
    $display("test defaults finished");
    // every array mode code, ending with ECC off.
    foreach (am_codes[i]) begin
      set_get(nfs_pkg::FA_ARRAY_MODE, am_codes[i]);
      chk(model.ecc_on, am_codes[i] == nfs_pkg::AM_ECC_ON);
    end
    $display("test array_mode finished");
    // all timing modes with junk in the reserved bits.
    for (int i = 0; i < 6; i++) set_get(nfs_pkg::FA_TIMING, {5'($urandom), 3'(i)});
    $display("test timing finished");
    // boundary, defined and random addresses with random values.
    for (int i = 0; i < 10; i++) begin
      case (i)
        0: a = 8'h00;
        1: a = 8'hFF;
        2: a = nfs_pkg::FA_DRIVE;
        3: a = nfs_pkg::FA_PULLDOWN;
        default: a = 8'($urandom);
      endcase
      set_get(a, 8'($urandom));
    end
    $display("test addresses finished");
    // a 6000 ns busy interval, longer than the host limit of 200 status-read clocks, is checked to end in a timeout.
    busy_ns = 6000;
    v = 8'($urandom);
    xfer(1'b0, nfs_pkg::FA_PULLDOWN, {24'h0, v}, got, tmo);
    shadow[nfs_pkg::FA_PULLDOWN] = clean(nfs_pkg::FA_PULLDOWN, v);
    chk(tmo, 1'b1);
    chk(busy_n, 1'b0);
    chk(req_ready, 1'b0);
    // A request made while still busy waits for ready; a slow legal busy interval completes.
    busy_ns = 3000;
    set_get(nfs_pkg::FA_DRIVE, 8'($urandom));
    busy_ns = 600;
    $display("test slow_target finished");
    // later writes leave earlier addresses untouched.
    foreach (am_codes[i]) begin
      a = (i == 0) ? nfs_pkg::FA_TIMING : (i == 1) ? nfs_pkg::FA_DRIVE :
          (i == 2) ? nfs_pkg::FA_PULLDOWN : nfs_pkg::FA_ARRAY_MODE;
      xfer(1'b1, a, 32'h0, got, tmo);
      chk(got, {24'h0, shadow[a]});
    end
    $display("test persistence finished");
    report_and_stop();
  end
endmodule
`default_nettype wire
